// *** rtl/ftm_flash_control.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ftm_defines.svh"
module ftm_flash_control #(
    parameter int CYC_PER_MS = `FTM_CYC_PER_MS,
    parameter int PWM_PERIOD = `FTM_PWM_PERIOD
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] sink_one_current_level,
    input wire logic [7:0] sink_two_current_level,
    input wire logic [3:0] indicator_duty,
    input wire logic [1:0] ext_torch_select,
    input wire logic torch_pin,
    input wire logic trigger_pin,
    output logic [7:0] sink_pin_one_level,
    output logic [7:0] sink_pin_two_level,
    output logic sink_pin_one_on,
    output logic sink_pin_two_on,
    output logic flash_active
);
    // the pwm counter is 9 bits and duty has 16 steps
    if (PWM_PERIOD < 16 || PWM_PERIOD > 511) begin : g_period_check
        $error("PWM_PERIOD out of range");
    end

    logic [7:0] duration_r;
    ftm_pkg::ftm_mode_type mode_r;
    logic enable_r;
    logic trig_enable_r;
    logic trig_level_r;
    logic timeout_flag_r;
    ftm_pkg::ftm_state_type state_r;
    ftm_pkg::ftm_state_type state_nxt;
    logic [1:0] trig_sync_r;
    logic [1:0] torch_sync_r;
    logic trig_prev_r;
    logic [8:0] pwm_cnt_r;
    logic pwm_on_r;
    logic [7:0] one_level_nxt;
    logic [7:0] two_level_nxt;
    logic on_nxt;
    logic timer_expired;
    logic pulse_end;
    logic armed;
    logic trig_rise;
    logic trig_fire;
    logic [13:0] pwm_threshold;

    // external pins pass two flops before use
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_sync_r <= 2'h0;
            torch_sync_r <= 2'h0;
            trig_prev_r <= 1'b0;
        end else begin
            trig_sync_r <= {trig_sync_r[0], trigger_pin};
            torch_sync_r <= {torch_sync_r[0], torch_pin};
            trig_prev_r <= trig_sync_r[1];
        end
    end

    assign trig_rise = trig_sync_r[1] && !trig_prev_r;
    assign armed = enable_r && (mode_r == ftm_pkg::FTM_MODE_FLASH);
    // trigger only matters in flash mode and when enabled
    assign trig_fire = !trig_enable_r ? 1'b1 :
        (trig_level_r ? trig_sync_r[1] : trig_rise); // R12

    always_comb begin
        state_nxt = state_r;
        pulse_end = 1'b0;
        unique case (state_r)
            ftm_pkg::FTM_ST_IDLE: begin
                if (armed && trig_fire) begin
                    state_nxt = ftm_pkg::FTM_ST_FLASH; // R13
                end
            end
            ftm_pkg::FTM_ST_FLASH: begin
                if (!armed) begin
                    state_nxt = ftm_pkg::FTM_ST_IDLE;
                end else if (timer_expired ||
                        (trig_enable_r && trig_level_r && !trig_sync_r[1])) begin
                    state_nxt = ftm_pkg::FTM_ST_IDLE;
                    pulse_end = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ftm_pkg::FTM_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign flash_active = (state_r == ftm_pkg::FTM_ST_FLASH);

    ftm_flash_timer #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_timer (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(flash_active),
        .duration_code(duration_r),
        .expired(timer_expired)
    );

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            duration_r <= `FTM_DURATION_RESET; // R01
        end else if (reg_wr && reg_addr == `FTM_ADDR_DURATION) begin
            duration_r <= reg_wdata;
        end
    end

    // the automatic clear outranks a host write in the same cycle,
    // otherwise a late write could re-arm a flash that just ended
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_r <= ftm_pkg::FTM_MODE_TORCH; // R04
            enable_r <= 1'b0; // R08
        end else if (pulse_end) begin
            mode_r <= ftm_pkg::FTM_MODE_TORCH; // R09
            enable_r <= 1'b0; // R09
        end else if (reg_wr && reg_addr == `FTM_ADDR_CONTROL) begin
            mode_r <= ftm_pkg::ftm_mode_type'(reg_wdata[1:0]);
            enable_r <= reg_wdata[`FTM_CTRL_ENABLE_BIT]; // R08
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_enable_r <= 1'b1; // R12
            trig_level_r <= 1'b1; // R12
        end else if (reg_wr && reg_addr == `FTM_ADDR_TRIGGER) begin
            trig_enable_r <= reg_wdata[`FTM_TRIG_ENABLE_BIT];
            trig_level_r <= reg_wdata[`FTM_TRIG_TYPE_BIT];
        end
    end

    // a timeout in the cycle of the clearing read is kept
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            timeout_flag_r <= 1'b0;
        end else if (timer_expired && flash_active) begin
            timeout_flag_r <= 1'b1; // R11
        end else if (reg_rd && reg_addr == `FTM_ADDR_FAULT) begin
            timeout_flag_r <= 1'b0; // R11
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `FTM_ADDR_DURATION: reg_rdata <= duration_r;
                // reserved bit 2 reads 0; the host must write it 0
                `FTM_ADDR_CONTROL: reg_rdata <= {4'h0, enable_r, 1'b0, mode_r}; // R10
                `FTM_ADDR_TRIGGER: reg_rdata <= {trig_enable_r, trig_level_r, 6'h00};
                `FTM_ADDR_FAULT: reg_rdata <= {3'h0, timeout_flag_r, 4'h0};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // 31.5 kHz period; duty is (indicator_duty+1)/16
    // operands widened first so the product keeps its carry bits
    assign pwm_threshold = ((14'(indicator_duty) + 14'h0001) * 14'(PWM_PERIOD)) >> 4;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwm_cnt_r <= 9'h000;
            pwm_on_r <= 1'b0;
        end else begin
            pwm_cnt_r <= (pwm_cnt_r == 9'(PWM_PERIOD - 1)) ? 9'h000 : pwm_cnt_r + 9'h001;
            pwm_on_r <= ({5'h00, pwm_cnt_r} < pwm_threshold); // R05
        end
    end

    // the ext torch mode drive level uses the 7-bit assist scaling
    always_comb begin
        one_level_nxt = 8'h00;
        two_level_nxt = 8'h00;
        on_nxt = 1'b0;
        unique case (mode_r)
            ftm_pkg::FTM_MODE_TORCH: begin
                one_level_nxt = {1'b0, sink_one_current_level[6:0]};
                two_level_nxt = {1'b0, sink_two_current_level[6:0]};
                on_nxt = (ext_torch_select == `FTM_EXT_TORCH_SELECT) && torch_sync_r[1]; // R04
            end
            ftm_pkg::FTM_MODE_INDICATOR: begin
                one_level_nxt = {2'h0, sink_one_current_level[5:0]}; // R05
                two_level_nxt = {2'h0, sink_two_current_level[5:0]}; // R05
                on_nxt = pwm_on_r; // R05
            end
            ftm_pkg::FTM_MODE_ASSIST: begin
                one_level_nxt = {1'b0, sink_one_current_level[6:0]}; // R06
                two_level_nxt = {1'b0, sink_two_current_level[6:0]}; // R06
                on_nxt = 1'b1;
            end
            ftm_pkg::FTM_MODE_FLASH: begin
                one_level_nxt = sink_one_current_level; // R07
                two_level_nxt = sink_two_current_level; // R07
                on_nxt = flash_active && !pulse_end;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sink_pin_one_level <= 8'h00;
            sink_pin_two_level <= 8'h00;
            sink_pin_one_on <= 1'b0;
            sink_pin_two_on <= 1'b0;
        end else begin
            sink_pin_one_level <= one_level_nxt;
            sink_pin_two_level <= two_level_nxt;
            sink_pin_one_on <= enable_r && on_nxt; // R08
            sink_pin_two_on <= enable_r && on_nxt; // R08
        end
    end
endmodule // ftm_flash_control
`default_nettype wire

// *** rtl/ftm_defines.svh ***
// Behaviour
// [R01] codes 00-7F: 2 ms steps, reset 23h
// [R02] codes 80-FF: (code-127)*8+256 ms
// [R03] host keeps full-current flash under 120 ms
// [R04] mode resets 00, external torch needs 10
// [R05] indicator: 6 LSBs, 31.5 kHz PWM duty
// [R06] assist light: 7 LSBs of each level
// [R07] flash: full current level value
// [R08] bit 3 enables sinks, resets 0
// [R09] pulse end clears enable and mode
// [R10] host writes 0 to control bit 2
// [R11] fault bit 4 timeout, clear on read
// [R12] trigger enable bit 7, type bit 6
// [R13] flash timer runs while flash is on
`ifndef FTM_DEFINES_SVH
`define FTM_DEFINES_SVH
`define FTM_ADDR_DURATION 8'h05
`define FTM_ADDR_CONTROL 8'h06
`define FTM_ADDR_TRIGGER 8'h07
`define FTM_ADDR_FAULT 8'h08
`define FTM_DURATION_RESET 8'h23
`define FTM_CTRL_ENABLE_BIT 3
`define FTM_TRIG_TYPE_BIT 6
`define FTM_TRIG_ENABLE_BIT 7
`define FTM_FAULT_TIMEOUT_BIT 4
`define FTM_EXT_TORCH_SELECT 2'h2
`define FTM_SHORT_STEP_MS 11'h002
`define FTM_LONG_STEP_SHIFT 3
`define FTM_LONG_BASE_MS 11'h100
`define FTM_LONG_OFFSET 11'h07F
`define FTM_CLK_HZ 10000000
`define FTM_PWM_HZ 31500
`define FTM_PWM_PERIOD (`FTM_CLK_HZ / `FTM_PWM_HZ)
`define FTM_CYC_PER_MS (`FTM_CLK_HZ / 1000)
`endif

// *** rtl/ftm_pkg.sv ***
package ftm_pkg;
    typedef enum logic [1:0] {
        FTM_MODE_TORCH = 2'b00,
        FTM_MODE_INDICATOR = 2'b01,
        FTM_MODE_ASSIST = 2'b10,
        FTM_MODE_FLASH = 2'b11
    } ftm_mode_type;
    typedef enum logic {
        FTM_ST_IDLE = 1'b0,
        FTM_ST_FLASH = 1'b1
    } ftm_state_type;
endpackage

// *** rtl/ftm_flash_timer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "ftm_defines.svh"
module ftm_flash_timer #(
    parameter int CYC_PER_MS = `FTM_CYC_PER_MS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [7:0] duration_code,
    output logic expired
);
    // the prescaler is 16 bits wide
    if (CYC_PER_MS < 1 || CYC_PER_MS > 65535) begin : g_cyc_check
        $error("CYC_PER_MS out of range");
    end

    logic [15:0] pre_r;
    logic [10:0] ms_r;
    logic [10:0] target_ms;
    logic done_r;
    logic tick;

    always_comb begin
        if (!duration_code[7]) begin
            target_ms = ({3'h0, duration_code} + 11'h001) * `FTM_SHORT_STEP_MS; // R01
        end else begin
            target_ms = (({3'h0, duration_code} - `FTM_LONG_OFFSET) << `FTM_LONG_STEP_SHIFT)
                + `FTM_LONG_BASE_MS; // R02
        end
    end

    assign tick = (pre_r == 16'(CYC_PER_MS - 1));

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_r <= 16'h0000;
        end else if (!run || tick) begin
            pre_r <= 16'h0000;
        end else begin
            pre_r <= pre_r + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_r <= 11'h000;
        end else if (!run) begin
            ms_r <= 11'h000;
        end else if (tick) begin
            ms_r <= ms_r + 11'h001;
        end
    end

    // one pulse per run; a held run after expiry does not refire
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
        end else if (!run) begin
            done_r <= 1'b0;
        end else if (expired) begin
            done_r <= 1'b1;
        end
    end

    assign expired = run && !done_r && tick && (ms_r == target_ms - 11'h001); // R13
endmodule // ftm_flash_timer
`default_nettype wire

// *** verification/ftm_flash_control_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module ftm_flash_control_chk #(
    parameter int CYC_PER_MS = 10000
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] sink_one_current_level,
    input wire logic [7:0] sink_two_current_level,
    input wire logic [7:0] sink_pin_one_level,
    input wire logic [7:0] sink_pin_two_level,
    input wire logic sink_pin_one_on,
    input wire logic sink_pin_two_on,
    input wire logic flash_active
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    logic [7:0] dur_r;
    logic lvl_r;
    logic [31:0] cnt_r;
    int tgt;
    // shadows of bus writes keep the length check free of internal probes
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dur_r <= 8'h23;
            lvl_r <= 1'b1;
        end else if (reg_wr && reg_addr == 8'h05) begin
            dur_r <= reg_wdata;
        end else if (reg_wr && reg_addr == 8'h07) begin
            lvl_r <= reg_wdata[7] & reg_wdata[6];
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 32'h0;
        end else begin
            cnt_r <= flash_active ? cnt_r + 32'h1 : 32'h0;
        end
    end
    always_comb begin
        tgt = CYC_PER_MS * (dur_r[7] ? (int'(dur_r) - 127) * 8 + 256 : (int'(dur_r) + 1) * 2);
    end
    a_ctrl_reserved_zero:
        assert property (reg_rd && reg_addr == 8'h06 |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2])
        else $error("control reads back reserved bits set");
    a_unmapped_reads_zero:
        assert property (reg_rd && (reg_addr < 8'h05 || reg_addr > 8'h08) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_duration_readback:
        assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata == $past(dur_r))
        else $error("duration readback wrong");
    a_flash_full_level:
        assert property ($past(flash_active) && flash_active |-> sink_pin_one_on && sink_pin_two_on
            && sink_pin_one_level == $past(sink_one_current_level)
            && sink_pin_two_level == $past(sink_two_current_level))
        else $error("flash drive level wrong");
    a_end_sinks_off:
        assert property ($fell(flash_active) |=> !sink_pin_one_on && !sink_pin_two_on)
        else $error("sinks still on after pulse end");
    a_flash_length:
        assert property ($fell(flash_active) && !lvl_r |-> cnt_r == tgt)
        else $error("flash length wrong");
    a_fault_read_clear:
        assert property (!flash_active && !$past(flash_active) && reg_rd && reg_addr == 8'h08
            ##2 reg_rd && reg_addr == 8'h08 |=> !reg_rdata[4])
        else $error("timeout flag not cleared by read");
    a_rdata_holds:
        assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
endmodule // ftm_flash_control_chk
bind ftm_flash_control ftm_flash_control_chk #(.CYC_PER_MS(CYC_PER_MS)) ftm_flash_control_chk_i (
    .sys_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .sink_one_current_level, .sink_two_current_level, .sink_pin_one_level,
    .sink_pin_two_level, .sink_pin_one_on, .sink_pin_two_on, .flash_active);
`default_nettype wire

// *** verification/ftm_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module ftm_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= (a == 8'h06) ? (d & 8'hFB) : d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule // ftm_host_model
`default_nettype wire

// *** verification/test_flash_timer_mode_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_flash_timer_mode_control;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pin1, pin2, rv;
    logic [7:0] lvl1 = 8'h00;
    logic [7:0] lvl2 = 8'h00;
    logic reg_wr, reg_rd, on1, on2, flash_active;
    logic [3:0] duty = 4'h0;
    logic [1:0] ext_sel = 2'h2;
    logic torch = 1'b1;
    logic trig = 1'b0;
    logic [7:0] codes [4] = '{8'h00, 8'h7F, 8'h80, 8'hFF};
    int miscompares = 0;
    int checks_done = 0;
    int n;
    always #50 sys_clk = ~sys_clk;
    ftm_flash_control #(.CYC_PER_MS(4), .PWM_PERIOD(16)) ftm_flash_control_i (
        .sys_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
        .sink_one_current_level(lvl1), .sink_two_current_level(lvl2),
        .indicator_duty(duty), .ext_torch_select(ext_sel), .torch_pin(torch),
        .trigger_pin(trig), .sink_pin_one_level(pin1), .sink_pin_two_level(pin2),
        .sink_pin_one_on(on1), .sink_pin_two_on(on2), .flash_active);
    ftm_host_model ftm_host_model_i (
        .sys_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h, want %0h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        ftm_host_model_i.rd(a, rv);
        chk(rv, exp);
    endtask
    function automatic int flash_cycles(input logic [7:0] c);
        return 4 * (c[7] ? (int'(c) - 127) * 8 + 256 : (int'(c) + 1) * 2);
    endfunction
    task automatic flash(input logic [7:0] code, input logic edge_trig);
        @(posedge sys_clk);
        lvl1 <= 8'($urandom_range(0, 254));
        lvl2 <= 8'($urandom_range(0, 254));
        ftm_host_model_i.wr(8'h05, code);
        rchk(8'h05, code);
        ftm_host_model_i.wr(8'h06, 8'h0B);
        if (edge_trig) begin
            repeat (8) tick();
            chk(flash_active, 1'b0);
            @(posedge sys_clk);
            trig <= 1'b1;
        end
        n = 0;
        while (flash_active !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        n = 0;
        while (flash_active === 1'b1 && n < 6000) begin
            tick();
            n++;
        end
        chk(n, flash_cycles(code));
        rchk(8'h06, 8'h00);
        rchk(8'h08, 8'h10);
        rchk(8'h08, 8'h00);
        @(posedge sys_clk);
        trig <= 1'b0;
    endtask
    task automatic end_sim();
        $display("miscompares %0d, checks_done %0d", miscompares, checks_done);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h5cad5b1f));
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rchk(8'h05, 8'h23);
        rchk(8'h06, 8'h00);
        rchk(8'h07, 8'hC0);
        rchk(8'h08, 8'h00);
        rchk(8'h09, 8'h00);
        ftm_host_model_i.wr(8'h07, 8'h80);
        flash(8'h01, 1'b1);
        ftm_host_model_i.wr(8'h07, 8'hC0);
        flash(8'h02, 1'b1);
        ftm_host_model_i.wr(8'h07, 8'h00);
        for (int i = 0; i < 7; i++) begin
            flash(i < 4 ? codes[i] : 8'($urandom_range(0, 63)), 1'b0);
        end
        for (int m = 0; m < 3; m++) begin
            @(posedge sys_clk);
            lvl1 <= 8'($urandom);
            lvl2 <= 8'($urandom);
            duty <= 4'($urandom);
            ftm_host_model_i.wr(8'h06, 8'h08 | 8'(m));
            repeat (4) tick();
            chk(pin1, lvl1 & (m == 1 ? 8'h3F : 8'h7F));
            chk(pin2, lvl2 & (m == 1 ? 8'h3F : 8'h7F));
            if (m == 1) begin
                n = 0;
                repeat (16) begin
                    tick();
                    n += int'(on1);
                end
                chk(n, 32'(duty) + 32'h1);
            end else begin
                chk({on1, on2}, 2'b11);
            end
        end
        @(posedge sys_clk);
        ext_sel <= 2'h1;
        ftm_host_model_i.wr(8'h06, 8'h08);
        repeat (4) tick();
        chk({on1, on2}, 2'b00);
        ftm_host_model_i.wr(8'h06, 8'h02);
        repeat (4) tick();
        chk({on1, on2}, 2'b00);
        end_sim();
    end
    // bound well above the longest flash sequence so a stuck pulse cannot hang the run
    initial begin
        #4000000;
        miscompares++;
        end_sim();
    end
endmodule // test_flash_timer_mode_control
`default_nettype wire
